// file: include/icc_pkg.sv
// Constants, types and helpers of the interrupt control block
// Assumes one 250 MHz clock and a synchronous active-low reset
package icc_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0]  ICC_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  ICC_OFS_FLAGS   = 8'h04;
    localparam logic [7:0]  ICC_OFS_ENABLE  = 8'h08;
    localparam logic [7:0]  ICC_OFS_PRIO    = 8'h0C;
    localparam logic [7:0]  ICC_OFS_RELOAD  = 8'h10;
    localparam logic [7:0]  ICC_OFS_STATUS  = 8'h14;
    localparam logic [7:0]  ICC_OFS_MASK    = 8'h18;
    localparam logic [7:0]  ICC_OFS_PEND    = 8'h1C;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int          ICC_SS_BIT      = 16;
    localparam int          ICC_MULTI_VECTOR_SELECT_BIT    = 12;
    localparam int          ICC_THR_LO      = 8;
    localparam int          ICC_THR_W       = 3;
    localparam int          ICC_EXT_N       = 5;
    localparam int          ICC_SRC_N       = 32;
    localparam int          ICC_VEC_W       = 5;
    localparam int          ICC_PRIO_W      = 24;
    localparam int          ICC_GRP_SZ      = 4;
    localparam int          ICC_RELOAD_W    = 16;
    localparam int          ICC_EV_N        = 2;
    localparam int          ICC_EV_PROX     = 0;
    localparam int          ICC_EV_EXT      = 1;
    localparam logic [31:0] ICC_CTRL_MASK   = 32'h0001171F;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] ICC_CTRL_RST    = 32'h00000000;
    localparam logic [31:0] ICC_FLAGS_RST   = 32'h00000000;
    localparam logic [31:0] ICC_ENABLE_RST  = 32'h00000000;
    localparam logic [23:0] ICC_PRIO_RST    = 24'h000000;
    localparam logic [15:0] ICC_RELOAD_RST  = 16'h0010;
    localparam logic [1:0]  ICC_EV_RST      = 2'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [0:0]
    {
        ICC_T_IDLE = 1'b0,
        ICC_T_RUN  = 1'b1
    } icc_tstate_t;

    // Group priority of one source, four sources per group
    function automatic logic [2:0] icc_src_prio
    (
        input logic [23:0] prio,
        input int          idx
    );
        icc_src_prio = prio[ICC_THR_W * (idx / ICC_GRP_SZ) +: ICC_THR_W];
    endfunction

endpackage

// file: include/icc_prox_if.sv
// Link between the control logic and the proximity timer
// Assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface icc_prox_if
    import icc_pkg::*;
();
    logic                    start;
    logic [ICC_RELOAD_W-1:0] reload;
    logic                    busy;
    logic                    expire;

    modport ctrl
    (
        output start,
        output reload,
        input  busy,
        input  expire
    );

    modport timer
    (
        input  start,
        input  reload,
        output busy,
        output expire
    );
endinterface

// file: hw/icc_edge_sync.sv
// Pin synchroniser and polarity edge detector, five inputs
// Assumes pins are asynchronous to the core clock
`timescale 1ns/1ps
module icc_edge_sync
    import icc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [ICC_EXT_N-1:0] pin,
    input  wire logic [ICC_EXT_N-1:0] pol,
    output      logic [ICC_EXT_N-1:0] edge_pulse
);
    logic [ICC_EXT_N-1:0] s1_r;
    logic [ICC_EXT_N-1:0] s2_r;
    logic [ICC_EXT_N-1:0] s3_r;
    logic [ICC_EXT_N-1:0] filt_r;
    logic [ICC_EXT_N-1:0] filt_nxt;
    logic [ICC_EXT_N-1:0] edge_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Level accepted only when stages two and three agree
    always_comb
    begin
        filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            filt_r <= '0;
            edge_r <= '0;
        end
        else
        begin
            filt_r <= filt_nxt;
            edge_r <= (pol & filt_nxt & ~filt_r)
                    | (~pol & ~filt_nxt & filt_r);
        end
    end

    assign edge_pulse = edge_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SYNC_HOLD: assert property (
        (s2_r ^ s3_r) != '0
        |=> ((filt_r ^ $past(filt_r)) & $past(s2_r ^ s3_r)) == '0)
        else $error("filtered level moved while stages disagreed");

    AST_SYNC_RISE: assert property (
        (pol[0] && !filt_r[0] && s2_r[0] && s3_r[0]) |=> ##0 edge_r[0])
        else $error("rising edge missed on input zero");
endmodule

// file: hw/icc_prox_timer.sv
// Interrupt proximity timer, reloadable down counter
// Assumes start is a same-clock level from the control logic
`timescale 1ns/1ps
module icc_prox_timer
    import icc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    icc_prox_if.timer px
);
    icc_tstate_t             state_r;
    logic [ICC_RELOAD_W-1:0] cnt_r;
    logic                    expire_r;

    // Runs for reload cycles once started, one cycle when reload is zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= ICC_T_IDLE;
            cnt_r   <= '0;
        end
        else
        begin
            case (state_r)
                ICC_T_IDLE:
                begin
                    if (px.start)
                    begin
                        state_r <= ICC_T_RUN;
                        cnt_r   <= (px.reload == '0) ? 16'h0001 : px.reload;
                    end
                end
                ICC_T_RUN:
                begin
                    if (cnt_r == 16'h0001)
                        state_r <= ICC_T_IDLE;
                    else
                        cnt_r <= cnt_r - 16'h0001;
                end
                default:
                    state_r <= ICC_T_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            expire_r <= 1'b0;
        else
            expire_r <= (state_r == ICC_T_RUN) && (cnt_r == 16'h0001);
    end

    assign px.busy   = (state_r == ICC_T_RUN);
    assign px.expire = expire_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_TMR_EXPIRE: assert property (
        (px.busy && cnt_r == 16'h0001) |=> (px.expire && !px.busy))
        else $error("timer did not expire after last count");
endmodule

// file: hw/icc_top.sv
// Interrupt control: control word, flags, enables, proximity timer
// Assumes a one-cycle strobe register port on the core clock
`timescale 1ns/1ps
module icc_top
    import icc_pkg::*;
(
    input  wire logic                 CORE_CLK,
    input  wire logic                 RESETN,
    input  wire logic [7:0]           REG_ADDR,
    input  wire logic [31:0]          REG_WDATA,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    output      logic [31:0]          REG_RDATA,
    input  wire logic [ICC_EXT_N-1:0] EXT_IRQ,
    input  wire logic [ICC_SRC_N-1:0] SRC_REQ,
    output      logic                 CORE_IRQ,
    output      logic [ICC_VEC_W-1:0] VEC_NUM,
    output      logic                 VEC_MULTI,
    output      logic                 VEC_SHADOW,
    output      logic                 PROX_BUSY,
    output      logic                 IRQ
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [31:0]             ctrl_r;
    logic [ICC_SRC_N-1:0]    flags_r;
    logic [ICC_SRC_N-1:0]    flags_nxt;
    logic [ICC_SRC_N-1:0]    enable_r;
    logic [ICC_PRIO_W-1:0]   prio_r;
    logic [ICC_RELOAD_W-1:0] reload_r;
    logic [ICC_EV_N-1:0]     status_r;
    logic [ICC_EV_N-1:0]     status_nxt;
    logic [ICC_EV_N-1:0]     mask_r;
    logic [31:0]             rdata_r;
    logic [31:0]             rdata_nxt;
    logic                    core_irq_r;
    logic [ICC_VEC_W-1:0]    vec_num_r;
    logic                    shadow_r;
    logic                    prox_busy_r;
    logic                    irq_r;
    logic [ICC_EXT_N-1:0]    ext_edge;
    logic [ICC_SRC_N-1:0]    set_vec;
    logic [ICC_SRC_N-1:0]    pend;
    logic [ICC_THR_W-1:0]    thr;
    logic                    start_hit;
    logic [ICC_THR_W-1:0]    best_prio;
    logic [ICC_VEC_W-1:0]    best_idx;
    logic                    wr_ctrl;
    logic                    wr_flags;
    logic                    wr_enable;
    logic                    wr_prio;
    logic                    wr_reload;
    logic                    wr_status;
    logic                    wr_mask;
    logic [ICC_EV_N-1:0]     events;

    icc_prox_if px_if ();

    // ****************************************
    // Submodules
    // ****************************************
    icc_edge_sync u_sync
    (
        .clk        (CORE_CLK),
        .rst_n      (RESETN),
        .pin        (EXT_IRQ),
        .pol        (ctrl_r[ICC_EXT_N-1:0]),
        .edge_pulse (ext_edge)
    );

    icc_prox_timer u_tmr
    (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .px    (px_if.timer)
    );

    // ****************************************
    // Write decode
    // ****************************************
    always_comb
    begin
        wr_ctrl   = 1'b0;
        wr_flags  = 1'b0;
        wr_enable = 1'b0;
        wr_prio   = 1'b0;
        wr_reload = 1'b0;
        wr_status = 1'b0;
        wr_mask   = 1'b0;
        if (REG_WR && REG_ADDR == ICC_OFS_CTRL)
            wr_ctrl = 1'b1;
        else if (REG_WR && REG_ADDR == ICC_OFS_FLAGS)
            wr_flags = 1'b1;
        else if (REG_WR && REG_ADDR == ICC_OFS_ENABLE)
            wr_enable = 1'b1;
        else if (REG_WR && REG_ADDR == ICC_OFS_PRIO)
            wr_prio = 1'b1;
        else if (REG_WR && REG_ADDR == ICC_OFS_RELOAD)
            wr_reload = 1'b1;
        else if (REG_WR && REG_ADDR == ICC_OFS_STATUS)
            wr_status = 1'b1;
        else if (REG_WR && REG_ADDR == ICC_OFS_MASK)
            wr_mask = 1'b1;
    end

    // ****************************************
    // Control word
    // ****************************************
    // Unimplemented positions never stored
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            ctrl_r <= ICC_CTRL_RST;
        else if (wr_ctrl)
            ctrl_r <= REG_WDATA & ICC_CTRL_MASK;
    end

    assign thr = ctrl_r[ICC_THR_LO +: ICC_THR_W];

    // Shadow set only with the single vector
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            shadow_r <= 1'b0;
        else
            shadow_r <= ctrl_r[ICC_SS_BIT] & ~ctrl_r[ICC_MULTI_VECTOR_SELECT_BIT];
    end

    // ****************************************
    // Request flags and enables
    // ****************************************
    always_comb
    begin
        set_vec = SRC_REQ;
        set_vec[ICC_EXT_N-1:0] = SRC_REQ[ICC_EXT_N-1:0] | ext_edge;
    end

    // Hardware set wins over software write
    always_comb
    begin
        flags_nxt = (wr_flags ? REG_WDATA : flags_r) | set_vec;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            flags_r <= ICC_FLAGS_RST;
        else
            flags_r <= flags_nxt;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            enable_r <= ICC_ENABLE_RST;
        else if (wr_enable)
            enable_r <= REG_WDATA;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            prio_r <= ICC_PRIO_RST;
        else if (wr_prio)
            prio_r <= REG_WDATA[ICC_PRIO_W-1:0];
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            reload_r <= ICC_RELOAD_RST;
        else if (wr_reload)
            reload_r <= REG_WDATA[ICC_RELOAD_W-1:0];
    end

    assign pend = flags_r & enable_r;

    // ****************************************
    // Proximity start
    // ****************************************
    // Enabled request at priority one to threshold
    always_comb
    begin
        start_hit = 1'b0;
        for (int i = 0; i < ICC_SRC_N; i++)
        begin
            if (set_vec[i] && enable_r[i] && thr != '0
                && icc_src_prio(prio_r, i) != '0
                && icc_src_prio(prio_r, i) <= thr)
                start_hit = 1'b1;
        end
    end

    assign px_if.start  = start_hit;
    assign px_if.reload = reload_r;

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            prox_busy_r <= 1'b0;
        else
            prox_busy_r <= px_if.busy;
    end

    // ****************************************
    // Vector selection
    // ****************************************
    // Highest group priority wins, lowest index on a tie
    always_comb
    begin
        best_prio = '0;
        best_idx  = '0;
        for (int i = 0; i < ICC_SRC_N; i++)
        begin
            if (pend[i] && icc_src_prio(prio_r, i) > best_prio)
            begin
                best_prio = icc_src_prio(prio_r, i);
                best_idx  = ICC_VEC_W'(i);
            end
        end
    end

    // Vector number only in multi-vector mode
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            vec_num_r <= '0;
        else
            vec_num_r <= ctrl_r[ICC_MULTI_VECTOR_SELECT_BIT] ? best_idx : '0;
    end

    // Core request held off while coalescing
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            core_irq_r <= 1'b0;
        else
            core_irq_r <= (|pend) & ~px_if.busy;
    end

    // ****************************************
    // Event status, mask, interrupt
    // ****************************************
    always_comb
    begin
        events = '0;
        events[ICC_EV_PROX] = px_if.expire;
        events[ICC_EV_EXT]  = |ext_edge;
        status_nxt = status_r;
        if (wr_status)
            status_nxt = status_r & ~REG_WDATA[ICC_EV_N-1:0];
        status_nxt = status_nxt | events;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            status_r <= ICC_EV_RST;
        else
            status_r <= status_nxt;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            mask_r <= ICC_EV_RST;
        else if (wr_mask)
            mask_r <= REG_WDATA[ICC_EV_N-1:0];
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            irq_r <= 1'b0;
        else
            irq_r <= |(status_r & mask_r);
    end

    // ****************************************
    // Read port
    // ****************************************
    always_comb
    begin
        rdata_nxt = '0;
        if (!REG_RD)
            rdata_nxt = '0;
        else if (REG_ADDR == ICC_OFS_CTRL)
            rdata_nxt = ctrl_r;
        else if (REG_ADDR == ICC_OFS_FLAGS)
            rdata_nxt = flags_r;
        else if (REG_ADDR == ICC_OFS_ENABLE)
            rdata_nxt = enable_r;
        else if (REG_ADDR == ICC_OFS_PRIO)
            rdata_nxt = {8'h00, prio_r};
        else if (REG_ADDR == ICC_OFS_RELOAD)
            rdata_nxt = {16'h0000, reload_r};
        else if (REG_ADDR == ICC_OFS_STATUS)
            rdata_nxt = {30'h0, status_r};
        else if (REG_ADDR == ICC_OFS_MASK)
            rdata_nxt = {30'h0, mask_r};
        else if (REG_ADDR == ICC_OFS_PEND)
            rdata_nxt = pend;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    assign REG_RDATA  = rdata_r;
    assign CORE_IRQ   = core_irq_r;
    assign VEC_NUM    = vec_num_r;
    assign VEC_MULTI  = ctrl_r[ICC_MULTI_VECTOR_SELECT_BIT];
    assign VEC_SHADOW = shadow_r;
    assign PROX_BUSY  = prox_busy_r;
    assign IRQ        = irq_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_ctrl_single_shadow;
        REG_WR && REG_ADDR == ICC_OFS_CTRL
        && REG_WDATA[ICC_SS_BIT] && !REG_WDATA[ICC_MULTI_VECTOR_SELECT_BIT];
    endsequence

    sequence s_prox_launch;
        px_if.start && !px_if.busy;
    endsequence

    AST_CTRL_RSVD: assert property (
        (REG_RD && REG_ADDR == ICC_OFS_CTRL)
        |=> (REG_RDATA & ~ICC_CTRL_MASK) == 32'h00000000)
        else $error("unimplemented control bits read nonzero");

    AST_SHADOW: assert property (
        s_ctrl_single_shadow |=> ##1 VEC_SHADOW)
        else $error("shadow set not presented for single vector");

    AST_MULTI: assert property (
        (REG_WR && REG_ADDR == ICC_OFS_CTRL)
        |=> VEC_MULTI == $past(REG_WDATA[ICC_MULTI_VECTOR_SELECT_BIT]))
        else $error("vector mode does not follow control write");

    AST_PROX_START: assert property (
        s_prox_launch |=> px_if.busy ##1 PROX_BUSY)
        else $error("proximity timer did not start");

    AST_PROX_OFF: assert property (
        thr == 3'h0 |-> !px_if.start)
        else $error("proximity timer started with zero threshold");

    AST_EXT_FLAG: assert property (
        ext_edge[0] |=> flags_r[0])
        else $error("external edge did not set its flag");

    AST_FLAG_SET: assert property (
        SRC_REQ != 32'h00000000
        |=> (flags_r & $past(SRC_REQ)) == $past(SRC_REQ))
        else $error("request did not set its flag");

    AST_EN_GATE: assert property (
        pend == 32'h00000000 |=> !CORE_IRQ)
        else $error("core request without enabled pending flag");
endmodule

// file: tb/icc_far_model.sv
// Far side model: external interrupt pins and the core
// Assumes the bench names pin levels; pins move off the clock edge
`timescale 1ns/1ps
module icc_far_model
    import icc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic [ICC_EXT_N-1:0] pin_cmd,
    input  wire logic                 core_irq,
    output      logic [ICC_EXT_N-1:0] pin,
    output      int                   irq_rises
);
    logic irq_q = 1'b0;

    // Pins are asynchronous: land well away from the edge
    assign #1.3 pin = pin_cmd;

    // Core side: counts each new interrupt request
    always @(posedge clk)
    begin
        irq_q <= core_irq;
        if (core_irq === 1'b1 && irq_q === 1'b0)
            irq_rises <= irq_rises + 1;
    end
endmodule

// file: tb/tb.sv
// Self-checking bench of the interrupt control block
// Assumes icc_pkg offsets and a one-cycle strobe register port
`timescale 1ns/1ps
module tb
    import icc_pkg::*;
;
    logic                 clk;
    logic                 rst_n;
    logic [7:0]           addr;
    logic [31:0]          wdata;
    logic                 wr;
    logic                 rd;
    logic [31:0]          rdata;
    logic [ICC_EXT_N-1:0] pin_cmd;
    logic [ICC_EXT_N-1:0] ext_pin;
    logic [ICC_SRC_N-1:0] src_req;
    logic                 core_irq;
    logic [ICC_VEC_W-1:0] vec_num;
    logic                 vec_multi;
    logic                 vec_shadow;
    logic                 prox_busy;
    logic                 irq;
    int                   irq_rises;
    int                   err_count;
    int                   checked;
    int                   cycles;
    int                   base;

    icc_top u_dut
    (
        .CORE_CLK   (clk),
        .RESETN     (rst_n),
        .REG_ADDR   (addr),
        .REG_WDATA  (wdata),
        .REG_WR     (wr),
        .REG_RD     (rd),
        .REG_RDATA  (rdata),
        .EXT_IRQ    (ext_pin),
        .SRC_REQ    (src_req),
        .CORE_IRQ   (core_irq),
        .VEC_NUM    (vec_num),
        .VEC_MULTI  (vec_multi),
        .VEC_SHADOW (vec_shadow),
        .PROX_BUSY  (prox_busy),
        .IRQ        (irq)
    );

    icc_far_model u_far
    (
        .clk       (clk),
        .pin_cmd   (pin_cmd),
        .core_irq  (core_irq),
        .pin       (ext_pin),
        .irq_rises (irq_rises)
    );

    // ****************************************
    // Clock, bus tasks, checks
    // ****************************************
    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            $display("unexpected hang: run cut short");
            test_done();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(nm, rdata, exp);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        src_req[i] <= 1'b1;
        @(posedge clk);
        src_req    <= '0;
    endtask

    task automatic pin_set(input int k, input logic v);
        @(posedge clk);
        pin_cmd[k] <= v;
        cyc(8);
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        rst_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        pin_cmd = '0;
        src_req = '0;
        err_count = 0;
        checked = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rchk("ctrl reset", ICC_OFS_CTRL, ICC_CTRL_RST);
        rchk("flags reset", ICC_OFS_FLAGS, 32'h0);
        rchk("enable reset", ICC_OFS_ENABLE, 32'h0);
        rchk("reload reset", ICC_OFS_RELOAD, {16'h0, ICC_RELOAD_RST});
        $display("test reset done");

        wr32(ICC_OFS_CTRL, 32'hFFFFFFFF);
        rchk("ctrl unimpl", ICC_OFS_CTRL, 32'h0001171F);
        cyc(2);
        chk("multi", vec_multi, 1'b1);
        chk("shadow in multi", vec_shadow, 1'b0);
        wr32(ICC_OFS_CTRL, 32'h00010000);
        cyc(2);
        chk("single", vec_multi, 1'b0);
        chk("shadow", vec_shadow, 1'b1);
        wr32(ICC_OFS_CTRL, 32'h0);
        cyc(2);
        chk("no shadow", vec_shadow, 1'b0);
        wr32(8'h20, 32'hFFFFFFFF);
        rchk("unmapped", 8'h20, 32'h0);
        $display("test control word done");

        wr32(ICC_OFS_FLAGS, 32'hA5A5A5A5);
        rchk("flags rw", ICC_OFS_FLAGS, 32'hA5A5A5A5);
        wr32(ICC_OFS_FLAGS, 32'h0);
        pulse(9);
        rchk("flag set", ICC_OFS_FLAGS, 32'h00000200);
        wr32(ICC_OFS_ENABLE, 32'hFFFFFFFF);
        rchk("enable rw", ICC_OFS_ENABLE, 32'hFFFFFFFF);
        wr32(ICC_OFS_ENABLE, 32'h0);
        cyc(3);
        chk("disabled", core_irq, 1'b0);
        base = irq_rises;
        wr32(ICC_OFS_PRIO, 32'h000000C0);
        wr32(ICC_OFS_ENABLE, 32'h00000200);
        cyc(3);
        chk("enabled", core_irq, 1'b1);
        chk("core saw", irq_rises - base, 32'd1);
        rchk("pending", ICC_OFS_PEND, 32'h00000200);
        wr32(ICC_OFS_CTRL, 32'h00001000);
        cyc(3);
        chk("vector", vec_num, 5'd9);
        wr32(ICC_OFS_CTRL, 32'h0);
        cyc(3);
        chk("single vector", vec_num, 5'd0);
        wr32(ICC_OFS_ENABLE, 32'h0);
        $display("test flags and enables done");

        for (int k = 0; k < ICC_EXT_N; k++)
        begin
            wr32(ICC_OFS_CTRL, 32'h1 << k);
            wr32(ICC_OFS_FLAGS, 32'h0);
            pin_set(k, 1'b1);
            rchk("rise pol1", ICC_OFS_FLAGS, 32'h1 << k);
            wr32(ICC_OFS_FLAGS, 32'h0);
            pin_set(k, 1'b0);
            rchk("fall pol1", ICC_OFS_FLAGS, 32'h0);
            wr32(ICC_OFS_CTRL, 32'h0);
            pin_set(k, 1'b1);
            rchk("rise pol0", ICC_OFS_FLAGS, 32'h0);
            pin_set(k, 1'b0);
            rchk("fall pol0", ICC_OFS_FLAGS, 32'h1 << k);
        end
        chk("masked", irq, 1'b0);
        wr32(ICC_OFS_MASK, 32'h2);
        cyc(2);
        chk("unmasked", irq, 1'b1);
        wr32(ICC_OFS_STATUS, 32'h2);
        cyc(2);
        chk("cleared", irq, 1'b0);
        rchk("status", ICC_OFS_STATUS, 32'h0);
        $display("test external pins done");

        wr32(ICC_OFS_FLAGS, 32'h0);
        wr32(ICC_OFS_ENABLE, 32'h1);
        for (int p = 1; p <= 2; p++)
        begin
            wr32(ICC_OFS_PRIO, p);
            for (int t = 0; t < 8; t++)
            begin
                wr32(ICC_OFS_CTRL, t << ICC_THR_LO);
                pulse(0);
                cyc(3);
                chk("timer start", prox_busy, t >= p);
                if (t >= p)
                    chk("held off", core_irq, 1'b0);
                cyc(20);
                chk("timer end", prox_busy, 1'b0);
            end
        end
        wr32(ICC_OFS_RELOAD, 32'h0);
        rchk("reload zero", ICC_OFS_RELOAD, 32'h0);
        pulse(0);
        cyc(1);
        chk("one cycle run", prox_busy, 1'b1);
        cyc(1);
        chk("run over", prox_busy, 1'b0);
        chk("resumed", core_irq, 1'b1);
        rchk("expired", ICC_OFS_STATUS, 32'h1);
        $display("test proximity timer done");
        test_done();
    end
endmodule
